// *** logic/hpc_pkg.sv ***
// Purpose: shared constants and types of the hibernate power control block
// Assumes: i_clk at 250 MHz; slow 32.768 kHz clock arrives as a sampled pin
// Notes:   battery level is given in millivolts by an external measuring stage
package hpc_pkg;

    typedef enum logic [3:0]
    {
        HPC_AWAKE = 4'h1,
        HPC_ENTER = 4'h2,
        HPC_HIBER = 4'h4,
        HPC_WAKE  = 4'h8
    } hpc_state_t;

    // slow clock rising edges that a write takes to complete in the slow domain
    localparam logic [1:0]  WR_SYNC_TICKS = 2'h2;

    // low battery thresholds in millivolts, selected by battery_low_flag_threshold_sel
    localparam logic [11:0] BATTERY_LOW_FLAG_MV_0 = 12'h76C;
    localparam logic [11:0] BATTERY_LOW_FLAG_MV_1 = 12'h834;
    localparam logic [11:0] BATTERY_LOW_FLAG_MV_2 = 12'h8FC;
    localparam logic [11:0] BATTERY_LOW_FLAG_MV_3 = 12'h9C4;

    // raw and masked interrupt status bit positions
    localparam int IRQ_BATTERY_LOW = 0;
    localparam int IRQ_CLOCK_MATCH = 1;
    localparam int IRQ_PIN_RESUME  = 2;
    localparam int IRQ_WRITE_DONE  = 3;
    localparam int IRQ_W           = 4;

    // reset values
    localparam logic [3:0]  IRQ_RESET  = 4'h0;
    localparam logic [1:0]  SEL_RESET  = 2'h0;

endpackage

// *** logic/hpc_write_sync.sv ***
// Purpose: carries one register write into the slow clock domain and back
// Assumes: i_slow_tick is a one-cycle pulse per slow clock rising edge
// Notes:   a toggle request is echoed by the slow side after the tick count
`timescale 1ns/1ps
module hpc_write_sync
(
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_start,
    input  wire logic i_slow_tick,
    output logic      o_busy,
    output logic      o_done
);

    typedef struct packed
    {
        logic       req;
        logic       ack;
        logic [1:0] ticks;
        logic       done;
    } hpc_wsync_t;

    hpc_wsync_t st_reg;
    hpc_wsync_t st_next;

    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (i_start && (st_reg.req == st_reg.ack))
        begin
            st_next.req   = ~st_reg.req;
            st_next.ticks = 2'h0;
        end
        else if ((st_reg.req != st_reg.ack) && i_slow_tick)
        begin
            // the slow side acknowledges only after enough of its own edges
            if (st_reg.ticks == hpc_pkg::WR_SYNC_TICKS - 2'h1)
            begin
                st_next.ack  = st_reg.req;
                st_next.done = 1'b1;
            end
            else
            begin
                st_next.ticks = st_reg.ticks + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_busy = (st_reg.req != st_reg.ack);
    assign o_done = st_reg.done;

endmodule

// *** logic/hpc_power_control.sv ***
// Purpose: hibernate power sequencer with low battery supervision
// Assumes: pins and the slow clock are asynchronous and are synchronised here
// Notes:   control writes take effect only when the slow domain completes them
`timescale 1ns/1ps
module hpc_power_control
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // register write port, peripheral clock side
    input  wire logic              i_wr_strobe,
    input  wire logic              i_wr_sleep_request,
    input  wire logic              i_wr_io_powered_mode,
    input  wire logic              i_wr_slow_osc_enable,
    input  wire logic              i_wr_osc_bypass,
    input  wire logic [1:0]        i_wr_battery_low_flag_threshold_sel,
    input  wire logic              i_wr_battery_low_flag_detect_enable,
    input  wire logic              i_wr_battery_abort_enable,
    input  wire logic              i_wr_battery_resume_enable,
    input  wire logic              i_wr_pin_resume_enable,
    input  wire logic              i_wr_clock_match_resume_enable,
    input  wire logic [3:0]        i_irq_mask,
    input  wire logic [3:0]        i_irq_clear,
    input  wire logic              i_run_clock_gating0,
    input  wire logic              i_run_clock_gate_sleepblk,
    // pins and neighbours
    input  wire logic              i_slow_clk,
    input  wire logic              i_main_supply_ok,
    input  wire logic              i_battery_valid,
    input  wire logic              i_resume_pin_n,
    input  wire logic              i_rtc_match,
    input  wire logic [11:0]       i_battery_mv,
    // outputs
    output logic                   o_regulator_off_n,
    output logic                   o_core_switch_off,
    output logic                   o_io_pins_hold,
    output logic                   o_hibernating,
    output logic                   o_regs_accessible,
    output logic                   o_write_done,
    output logic                   o_slow_osc_enable,
    output logic                   o_osc_bypass,
    output logic [3:0]             o_raw_irq_status,
    output logic [3:0]             o_masked_irq_status,
    output logic                   o_irq
);

    typedef struct packed
    {
        hpc_pkg::hpc_state_t state;
        logic [2:0]  slow_sync;
        logic [1:0]  supply_sync;
        logic [1:0]  batt_sync;
        logic [1:0]  resume_sync;
        // pending write, captured at the strobe
        logic        p_sleep;
        logic        p_io_mode;
        logic        p_osc_en;
        logic        p_bypass;
        logic [1:0]  p_sel;
        logic        p_lb_en;
        logic        p_abort;
        logic        p_batwake;
        logic        p_pinwake;
        logic        p_rtcwake;
        // applied control
        logic        io_mode;
        logic        osc_en;
        logic        bypass;
        logic [1:0]  sel;
        logic        lb_en;
        logic        abort;
        logic        batwake;
        logic        pinwake;
        logic        rtcwake;
        logic        sleep_go;
        logic        write_done;
        logic [3:0]  raw;
        logic        reg_off_n;
        logic        core_off;
    } hpc_regs_t;

    hpc_regs_t st_reg;
    hpc_regs_t st_next;

    logic accessible;
    logic slow_tick;
    logic wr_busy;
    logic wr_done;
    logic battery_low;
    logic wake_event;
    logic supply_lost;
    logic resume_pin;
    logic [3:0] irq_set;

    function automatic logic [11:0] threshold_mv(input logic [1:0] sel);
        logic [11:0] mv;
        mv = hpc_pkg::BATTERY_LOW_FLAG_MV_0;
        unique case (sel)
            2'h0: mv = hpc_pkg::BATTERY_LOW_FLAG_MV_0;
            2'h1: mv = hpc_pkg::BATTERY_LOW_FLAG_MV_1;
            2'h2: mv = hpc_pkg::BATTERY_LOW_FLAG_MV_2;
            2'h3: mv = hpc_pkg::BATTERY_LOW_FLAG_MV_3;
        endcase
        return mv;
    endfunction

    assign accessible  = i_run_clock_gating0 | i_run_clock_gate_sleepblk;
    assign slow_tick   = st_reg.slow_sync[1] & ~st_reg.slow_sync[2];
    assign battery_low = (i_battery_mv < threshold_mv(st_reg.sel));
    assign supply_lost = ~st_reg.supply_sync[1] & st_reg.batt_sync[1];
    assign resume_pin  = ~st_reg.resume_sync[1];
    assign wake_event  = (st_reg.pinwake & resume_pin)
                       | (st_reg.rtcwake & i_rtc_match)
                       | (st_reg.batwake & st_reg.lb_en & battery_low);

    always_comb
    begin
        irq_set                  = '0;
        irq_set[hpc_pkg::IRQ_BATTERY_LOW] = st_reg.lb_en & battery_low;
        irq_set[hpc_pkg::IRQ_CLOCK_MATCH] = i_rtc_match;
        irq_set[hpc_pkg::IRQ_PIN_RESUME]  = resume_pin & (st_reg.state == hpc_pkg::HPC_HIBER);
        irq_set[hpc_pkg::IRQ_WRITE_DONE]  = wr_done;
    end

    hpc_write_sync u_write_sync
    (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_start     (i_wr_strobe & accessible & ~wr_busy & ~wr_done),
        .i_slow_tick (slow_tick),
        .o_busy      (wr_busy),
        .o_done      (wr_done)
    );

    always_comb
    begin
        st_next             = st_reg;
        st_next.slow_sync   = {st_reg.slow_sync[1:0], i_slow_clk};
        st_next.supply_sync = {st_reg.supply_sync[0], i_main_supply_ok};
        st_next.batt_sync   = {st_reg.batt_sync[0], i_battery_valid};
        st_next.resume_sync = {st_reg.resume_sync[0], i_resume_pin_n};
        st_next.sleep_go    = 1'b0;

        // gated clock: writes are dropped, and so are writes during a transfer
        // a strobe in the completion cycle is dropped too, or write_done would
        // rise over a fresh write still in flight
        if (i_wr_strobe && accessible && !wr_busy && !wr_done)
        begin
            st_next.write_done = 1'b0;
            st_next.p_sleep    = i_wr_sleep_request;
            st_next.p_io_mode  = i_wr_io_powered_mode;
            st_next.p_osc_en   = i_wr_slow_osc_enable;
            st_next.p_bypass   = i_wr_osc_bypass;
            st_next.p_sel      = i_wr_battery_low_flag_threshold_sel;
            st_next.p_lb_en    = i_wr_battery_low_flag_detect_enable;
            st_next.p_abort    = i_wr_battery_abort_enable;
            st_next.p_batwake  = i_wr_battery_resume_enable;
            st_next.p_pinwake  = i_wr_pin_resume_enable;
            st_next.p_rtcwake  = i_wr_clock_match_resume_enable;
        end
        if (wr_done)
        begin
            st_next.write_done = 1'b1;
            st_next.io_mode    = st_reg.p_io_mode;
            st_next.osc_en     = st_reg.p_osc_en;
            st_next.bypass     = st_reg.p_bypass;
            st_next.sel        = st_reg.p_sel;
            st_next.lb_en      = st_reg.p_lb_en;
            st_next.abort      = st_reg.p_abort;
            st_next.batwake    = st_reg.p_batwake;
            st_next.pinwake    = st_reg.p_pinwake;
            st_next.rtcwake    = st_reg.p_rtcwake;
            st_next.sleep_go   = st_reg.p_sleep;
        end

        // set wins over clear
        st_next.raw = (st_reg.raw & ~i_irq_clear) | irq_set;

        unique case (st_reg.state)
            hpc_pkg::HPC_AWAKE:
            begin
                if (supply_lost)
                begin
                    st_next.state = hpc_pkg::HPC_ENTER;
                end
                else if (st_reg.sleep_go && (st_reg.pinwake || st_reg.rtcwake)
                         && !(st_reg.abort && st_reg.lb_en && battery_low))
                begin
                    st_next.state = hpc_pkg::HPC_ENTER;
                end
            end
            hpc_pkg::HPC_ENTER:
            begin
                if (st_reg.io_mode)
                begin
                    st_next.core_off = 1'b1;
                end
                else
                begin
                    st_next.reg_off_n = 1'b0;
                end
                st_next.state = hpc_pkg::HPC_HIBER;
            end
            hpc_pkg::HPC_HIBER:
            begin
                if (wake_event)
                begin
                    st_next.reg_off_n = 1'b1;
                    st_next.core_off  = 1'b0;
                    st_next.state     = hpc_pkg::HPC_WAKE;
                end
            end
            hpc_pkg::HPC_WAKE:
            begin
                // the chip reset itself comes from the returning supply
                if (st_reg.supply_sync[1])
                begin
                    st_next.state = hpc_pkg::HPC_AWAKE;
                end
            end
            default:
            begin
                st_next.state = hpc_pkg::HPC_AWAKE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            st_reg            <= '0;
            st_reg.state      <= hpc_pkg::HPC_AWAKE;
            st_reg.sel        <= hpc_pkg::SEL_RESET;
            st_reg.raw        <= hpc_pkg::IRQ_RESET;
            st_reg.write_done <= 1'b1;
            st_reg.reg_off_n  <= 1'b1;
            // pin idles high, so no false press right after reset
            st_reg.resume_sync <= 2'h3;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // reads are register views valid every cycle, except the access flag (OR of the two gating inputs) and masked status and irq (raw AND i_irq_mask)
    assign o_regulator_off_n   = st_reg.reg_off_n;
    assign o_core_switch_off   = st_reg.core_off;
    assign o_io_pins_hold      = st_reg.core_off;
    assign o_hibernating       = (st_reg.state == hpc_pkg::HPC_HIBER);
    assign o_regs_accessible   = accessible;
    assign o_write_done        = st_reg.write_done;
    assign o_slow_osc_enable   = st_reg.osc_en;
    assign o_osc_bypass        = st_reg.bypass;
    assign o_raw_irq_status    = st_reg.raw;
    assign o_masked_irq_status = st_reg.raw & i_irq_mask;
    assign o_irq               = |(st_reg.raw & i_irq_mask);

endmodule

// *** verif/hpc_power_control_assertions.sv ***
// Purpose: port-level checks on the hibernate power control block
// Assumes: slow clock edges arrive well inside the write completion bound
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module hpc_power_control_assertions
(
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    input wire logic       i_wr_strobe,
    input wire logic [3:0] i_irq_mask,
    input wire logic       i_run_clock_gating0,
    input wire logic       i_run_clock_gate_sleepblk,
    input wire logic       o_regulator_off_n,
    input wire logic       o_core_switch_off,
    input wire logic       o_io_pins_hold,
    input wire logic       o_hibernating,
    input wire logic       o_regs_accessible,
    input wire logic       o_write_done,
    input wire logic [3:0] o_raw_irq_status,
    input wire logic [3:0] o_masked_irq_status,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    mask_view_a:
        assert property (o_masked_irq_status == (o_raw_irq_status & i_irq_mask))
        else $error("masked status differs from raw and mask");
    irq_any_a:
        assert property (o_irq == (|o_masked_irq_status)) else $error("irq not the masked OR");
    gate_view_a:
        assert property (o_regs_accessible == (i_run_clock_gating0 | i_run_clock_gate_sleepblk))
        else $error("access flag wrong for gating bits");
    write_start_a:
        assert property (i_wr_strobe && o_regs_accessible && o_write_done |=> !o_write_done)
        else $error("write done did not drop on a taken write");
    gated_hold_a:
        assert property (i_wr_strobe && !o_regs_accessible && o_write_done |=> o_write_done)
        else $error("gated write was taken");
    write_bound_a:
        assert property ($fell(o_write_done) |-> ##[2:120] o_write_done)
        else $error("write never completed");
    done_flag_a:
        assert property ($rose(o_write_done) |-> o_raw_irq_status[3])
        else $error("write completion not in raw status");
    reg_off_hib_a:
        assert property (!o_regulator_off_n |-> o_hibernating) else $error("regulator off awake");
    core_off_a:
        assert property (o_core_switch_off |-> o_hibernating && o_io_pins_hold && o_regulator_off_n)
        else $error("core switch off outside io mode hibernation");
    wake_release_a:
        assert property ($fell(o_hibernating) |-> o_regulator_off_n && !o_core_switch_off)
        else $error("power not restored on wake");
    cover property (o_hibernating && !o_regulator_off_n);
    cover property (o_hibernating && o_core_switch_off);
    cover property ($fell(o_hibernating));
    cover property (i_wr_strobe && !o_regs_accessible);
endmodule
bind hpc_power_control hpc_power_control_assertions u_hpc_chk
(
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr_strobe(i_wr_strobe), .i_irq_mask(i_irq_mask),
    .i_run_clock_gating0(i_run_clock_gating0),
    .i_run_clock_gate_sleepblk(i_run_clock_gate_sleepblk),
    .o_regulator_off_n(o_regulator_off_n), .o_core_switch_off(o_core_switch_off),
    .o_io_pins_hold(o_io_pins_hold), .o_hibernating(o_hibernating),
    .o_regs_accessible(o_regs_accessible), .o_write_done(o_write_done),
    .o_raw_irq_status(o_raw_irq_status), .o_masked_irq_status(o_masked_irq_status),
    .o_irq(o_irq)
);

// *** verif/hpc_supply_model.sv ***
// Purpose: external regulator and resume push button beside the block
// Assumes: supply follows the regulator enable after a short settling time
// Notes:   resume pin has a pull-up, so it idles high
`timescale 1ns/1ps
module hpc_supply_model
#(
    parameter int DROP = 5,
    parameter int RISE = 9
)
(
    input  wire logic i_clk,
    input  wire logic i_regulator_off_n,
    input  wire logic i_cut,
    input  wire logic i_press,
    output logic      o_main_supply_ok,
    output logic      o_resume_pin_n
);
    int   cnt = 0;
    logic up  = 1'b1;
    // supply lags the enable, so a wake never sees power at once
    always @(posedge i_clk)
    begin
        if (i_regulator_off_n == up)
            cnt <= 0;
        else if (cnt == (up ? DROP : RISE))
        begin
            up  <= !up;
            cnt <= 0;
        end
        else
            cnt <= cnt + 1;
    end
    assign o_main_supply_ok = up && !i_cut;
    assign o_resume_pin_n   = !i_press;
endmodule

// *** verif/hpc_power_control_test.sv ***
// Purpose: self-checking bench for the hibernate power control block
// Assumes: slow clock sped up to 16 i_clk cycles to keep the run short
// Notes:   inputs change and outputs are read on the falling edge
`timescale 1ns/1ps
module hpc_power_control_test;
    typedef struct {logic io, pw, rw, ab; logic [1:0] sel; logic [11:0] mv; logic regulator_off_n;} hpc_row_t;
    logic        i_clk = 0, i_reset_n = 0, stb = 0, slp = 0, io = 0, osc = 0, byp = 0;
    logic        lben = 0, ab = 0, bw = 0, pw = 0, rw = 0, g0 = 1, g1 = 1, slow = 0;
    logic        bat_ok = 1, rtc = 0, cut = 0, press = 0;
    logic [1:0]  sel = 2'h0;
    logic [3:0]  mask = 4'h0, clr = 4'h0, raw, mis;
    logic [11:0] mv = 12'hBB8;
    logic        sup, pin_n, off_n, core, hold, regulator_off_n, acc, done, osc_q, byp_q, irq;
    logic [11:0] thr [4] = '{hpc_pkg::BATTERY_LOW_FLAG_MV_0, hpc_pkg::BATTERY_LOW_FLAG_MV_1,
                             hpc_pkg::BATTERY_LOW_FLAG_MV_2, hpc_pkg::BATTERY_LOW_FLAG_MV_3};
    hpc_row_t    rows [12];
    int          failures = 0, total_checks = 0;

    hpc_power_control dut
    (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_wr_strobe(stb), .i_wr_sleep_request(slp),
        .i_wr_io_powered_mode(io), .i_wr_slow_osc_enable(osc), .i_wr_osc_bypass(byp),
        .i_wr_battery_low_flag_threshold_sel(sel), .i_wr_battery_low_flag_detect_enable(lben),
        .i_wr_battery_abort_enable(ab), .i_wr_battery_resume_enable(bw),
        .i_wr_pin_resume_enable(pw), .i_wr_clock_match_resume_enable(rw), .i_irq_mask(mask),
        .i_irq_clear(clr), .i_run_clock_gating0(g0), .i_run_clock_gate_sleepblk(g1),
        .i_slow_clk(slow), .i_main_supply_ok(sup), .i_battery_valid(bat_ok),
        .i_resume_pin_n(pin_n), .i_rtc_match(rtc), .i_battery_mv(mv), .o_regulator_off_n(off_n),
        .o_core_switch_off(core), .o_io_pins_hold(hold), .o_hibernating(regulator_off_n),
        .o_regs_accessible(acc), .o_write_done(done), .o_slow_osc_enable(osc_q),
        .o_osc_bypass(byp_q), .o_raw_irq_status(raw), .o_masked_irq_status(mis), .o_irq(irq)
    );
    hpc_supply_model u_sup
    (
        .i_clk(i_clk), .i_regulator_off_n(off_n), .i_cut(cut), .i_press(press),
        .o_main_supply_ok(sup), .o_resume_pin_n(pin_n)
    );

    initial forever #2 i_clk = ~i_clk;
    // unrelated phase to the main clock
    initial
    begin
        #1;
        forever #32 slow = ~slow;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // oscillator bits always set: external oscillator, so no startup wait
    task automatic wr(input logic s, m, p, r, a, l, b, input logic [1:0] t);
        {slp, io, pw, rw, ab, lben, bw, sel} = {s, m, p, r, a, l, b, t};
        {osc, byp, stb} = 3'h7;
        @(negedge i_clk);
        stb = 1'b0;
        chk(done, !acc, "write done after strobe");
        for (int n = 0; n < 200 && done !== 1'b1; n++)
            @(negedge i_clk);
        chk(done, 1'b1, "write completion");
    endtask

    task automatic wait_hib(input logic want);
        for (int n = 0; n < 300 && regulator_off_n !== want; n++)
            @(negedge i_clk);
        chk(regulator_off_n, want, "hibernating");
    endtask

    // the pin is pressed first even when only a clock match may wake
    task automatic wake(input logic by_pin);
        press = 1'b1;
        repeat (6) @(negedge i_clk);
        press = 1'b0;
        if (!by_pin)
        begin
            chk(regulator_off_n, 1'b1, "pin wake while disabled");
            rtc = 1'b1;
            @(negedge i_clk);
            rtc = 1'b0;
        end
        wait_hib(1'b0);
        chk(off_n, 1'b1, "regulator on after wake");
        for (int n = 0; n < 300 && sup !== 1'b1; n++)
            @(negedge i_clk);
        repeat (6) @(negedge i_clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #200000;
        failures++;
        $display("wrong value at %0t: run hung", $time);
        wrap_up();
    end

    initial
    begin
        rows[0:3] = '{'{0, 1, 0, 0, 0, 12'hBB8, 1}, '{0, 0, 1, 0, 0, 12'hBB8, 1},
                      '{1, 1, 0, 0, 0, 12'hBB8, 1}, '{0, 0, 0, 0, 0, 12'hBB8, 0}};
        // each threshold just below (refused) and at (accepted)
        for (int s = 0; s < 4; s++)
        begin
            rows[4 + 2 * s] = '{0, 1, 0, 1, 2'(s), thr[s] - 12'h1, 0};
            rows[5 + 2 * s] = '{0, 1, 0, 1, 2'(s), thr[s], 1};
        end
        repeat (8) @(negedge i_clk);
        i_reset_n = 1'b1;
        wr(0, 0, 0, 0, 0, 0, 0, 2'h0);
        chk({osc_q, byp_q}, 2'h3, "oscillator bits");
        foreach (rows[i])
        begin
            mv = rows[i].mv;
            wr(1, rows[i].io, rows[i].pw, rows[i].rw, rows[i].ab, rows[i].ab, 0, rows[i].sel);
            repeat (6) @(negedge i_clk);
            chk(regulator_off_n, rows[i].regulator_off_n, "row hibernation");
            chk(off_n, !(rows[i].regulator_off_n && !rows[i].io), "row regulator");
            chk({core, hold}, {2{rows[i].regulator_off_n && rows[i].io}}, "row core switch");
            if (rows[i].regulator_off_n)
                wake(rows[i].pw);
        end
        mask = 4'h8;
        @(negedge i_clk);
        chk({raw[3], mis, irq}, 6'h31, "write done irq");
        {mask, clr} = 8'h0F;
        @(negedge i_clk);
        clr = 4'h0;
        chk({raw, irq}, 5'h00, "irq cleared and masked");
        mv = thr[0] - 12'h1;
        wr(0, 0, 0, 0, 0, 1, 0, 2'h0);
        mask = 4'h1;
        repeat (3) @(negedge i_clk);
        chk({raw[0], irq}, 2'h3, "low battery flag");
        wr(0, 0, 0, 0, 0, 0, 0, 2'h0);
        clr = 4'h1;
        @(negedge i_clk);
        clr = 4'h0;
        repeat (3) @(negedge i_clk);
        chk(raw[0], 1'b0, "low battery flag off");
        mv = 12'hBB8;
        wr(1, 0, 1, 0, 0, 1, 1, 2'h0);
        wait_hib(1'b1);
        mv = thr[0] - 12'h1;
        wait_hib(1'b0);
        wake(1'b1);
        mv = 12'hBB8;
        wr(0, 0, 1, 0, 0, 0, 0, 2'h0);
        {bat_ok, cut} = 2'h1;
        repeat (10) @(negedge i_clk);
        chk(regulator_off_n, 1'b0, "supply loss without battery");
        {bat_ok, cut} = 2'h2;
        repeat (4) @(negedge i_clk);
        cut = 1'b1;
        wait_hib(1'b1);
        cut = 1'b0;
        wake(1'b1);
        i_reset_n = 1'b0;
        repeat (4) @(negedge i_clk);
        i_reset_n = 1'b1;
        chk({off_n, core, done, raw, osc_q}, 8'hA0, "reset values");
        {g0, g1} = 2'h0;
        wr(0, 0, 0, 0, 0, 0, 0, 2'h0);
        repeat (60) @(negedge i_clk);
        chk({acc, osc_q}, 2'h0, "gated write ignored");
        g1 = 1'b1;
        wr(0, 0, 0, 0, 0, 0, 0, 2'h0);
        chk(osc_q, 1'b1, "write with one gate bit");
        wrap_up();
    end
endmodule
